// ---- verilog/sslr_defines.vh ----
`ifndef SSLR_DEFINES_VH
`define SSLR_DEFINES_VH

// ==========================================================
// register map (byte addresses, one 32-bit word each)
`define SSLR_REG_CTRL      12'h000
`define SSLR_REG_CODE      12'h004
`define SSLR_REG_STATUS    12'h008
`define SSLR_REG_CFG       12'h00C
`define SSLR_REG_BOOT      12'h010
`define SSLR_REG_TIMING    12'h014

// ==========================================================
// ctrl fields
`define SSLR_CTRL_TEST_DONE   0
`define SSLR_CTRL_TEST_FAIL   1
`define SSLR_CTRL_INIT_DONE   2
`define SSLR_CTRL_STEADY      3
`define SSLR_CTRL_CFG_FAIL    4
`define SSLR_CTRL_RESTART     5

// ==========================================================
// fault code ranges and fixed values
`define SSLR_CFG_CODE_BASE    8'hA0
`define SSLR_TEST_CODE_BASE   8'hB0
`define SSLR_TEST_CODE_LAST   8'hBA
`define SSLR_CODE_BAD_ADDR    8'hA0
`define SSLR_CODE_BAD_FORMAT  8'hA7
`define SSLR_CODE_BAD_HOSTS   8'hAC
`define SSLR_CODE_BOOT_FAIL   8'hAF
`define SSLR_CODE_SYSTEM      8'hBA
`define SSLR_HOSTS_DEFAULT    8'hFF
`define SSLR_HOSTS_FIRST      8'h00
`define SSLR_RSVD_REQ         24'h000001
`define SSLR_BOOT_SUBTYPE     16'h0000
`define SSLR_BOOT_FRAME_TYPE  16'h1080

// ==========================================================
// timing (ms) and clock rate
`define SSLR_CLK_HZ           25000000
`define SSLR_LONG_MS          600
`define SSLR_SHORT_MS         200
`define SSLR_GAP_MS           300
`define SSLR_PAUSE_MS         1500
`define SSLR_BLINK_MS         250
`define SSLR_TICK_HZ          1000
`define SSLR_TICK_CYCLES      (`SSLR_CLK_HZ / `SSLR_TICK_HZ)

`endif

// ---- verilog/sslr_code_store.v ----
`default_nettype none

// ==========================================================
// small code store: latched fault code with registered read data
module sslr_code_store #(
    parameter WIDTH = 8
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             wr_en,
    input  wire [WIDTH-1:0] wr_data,
    output reg  [WIDTH-1:0] rd_data
);

    // store and present the code; one write overwrites the last
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rd_data <= {WIDTH{1'b0}};
        else if (wr_en)
            rd_data <= wr_data;
    end

endmodule

`default_nettype wire

// ---- verilog/sslr_top.v ----
`include "sslr_defines.vh"
`default_nettype none

// Functional notes
// - indicator on from reset through self test
// - even blinking after pass until initialized
// - indicator off once initialized
// - hardware fault: steady on or code
// - software config failure shows pulsed code
// - eight-bit code, most significant bit first
// - long pulse one, short pulse zero
// - code repeats with long leading pause
// - config failures coded A0h to AFh
// - self test failures coded B0h to BAh
// - host count 0FFh first time means zero
// - boot subtype zero, frame type 1080h
module sslr_top #(
    parameter TICK_CYCLES  = `SSLR_TICK_CYCLES,
    parameter LONG_TICKS   = `SSLR_LONG_MS,
    parameter SHORT_TICKS  = `SSLR_SHORT_MS,
    parameter GAP_TICKS    = `SSLR_GAP_MS,
    parameter PAUSE_TICKS  = `SSLR_PAUSE_MS,
    parameter BLINK_TICKS  = `SSLR_BLINK_MS
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output reg         status_indicator
);

    // ======================================================
    // states
    localparam ST_TEST  = 3'd0;
    localparam ST_READY = 3'd1;
    localparam ST_INIT  = 3'd2;
    localparam ST_HOLD  = 3'd3;
    localparam ST_CODE  = 3'd4;

    localparam PH_PAUSE = 2'd0;
    localparam PH_PULSE = 2'd1;
    localparam PH_GAP   = 2'd2;

    // ======================================================
    // decode helper used by read and write paths
    function hit;
        input [11:0] addr;
        input [11:0] reg_addr;
        begin
            hit = (addr[11:2] == reg_addr[11:2]);
        end
    endfunction

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [1:0]  phase;
    reg  [2:0]  bit_idx;
    reg  [15:0] ticks;
    reg  [31:0] div;
    reg         tick;
    reg         blink;
    reg         code_wr;
    reg  [7:0]  code_wr_data;
    reg  [7:0]  sw_code;
    reg  [7:0]  hosts_in;
    reg  [7:0]  hosts_eff;
    reg         first_cfg;
    reg  [23:0] rsvd_in;
    reg  [15:0] boot_sub;
    reg  [15:0] boot_type;
    reg         restart;
    wire [7:0]  code;
    wire        wr;
    wire        rd;
    wire        mapped;
    wire        cur_bit;
    wire [15:0] pulse_len;

    // ======================================================
    // apb slave: zero wait states, error on unmapped word
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~pwrite;
    assign pready = 1'b1;
    assign mapped = hit(paddr, `SSLR_REG_CTRL) |
                    hit(paddr, `SSLR_REG_CODE) |
                    hit(paddr, `SSLR_REG_STATUS) |
                    hit(paddr, `SSLR_REG_CFG) |
                    hit(paddr, `SSLR_REG_BOOT) |
                    hit(paddr, `SSLR_REG_TIMING);
    assign pslverr = psel & penable & ~mapped;

    // tick divider: one enable pulse per millisecond
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div  <= 32'h0000_0000;
            tick <= 1'b0;
        end
        else if (div >= TICK_CYCLES - 1)
        begin
            div  <= 32'h0000_0000;
            tick <= 1'b1;
        end
        else
        begin
            div  <= div + 32'h0000_0001;
            tick <= 1'b0;
        end
    end

    // configuration and boot fields written by the host/sequencer
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hosts_in  <= 8'h00;
            rsvd_in   <= 24'h000000;
            boot_sub  <= 16'h0000;
            boot_type <= 16'h0000;
            hosts_eff <= 8'h00;
            first_cfg <= 1'b1;
        end
        else if (wr && hit(paddr, `SSLR_REG_CFG))
        begin
            hosts_in  <= pwdata[7:0];
            rsvd_in   <= pwdata[31:8];
            first_cfg <= 1'b0;
            // a default on first configuration means no hosts
            if (first_cfg && pwdata[7:0] == `SSLR_HOSTS_DEFAULT)
                hosts_eff <= `SSLR_HOSTS_FIRST;
            else if (pwdata[7:0] != `SSLR_HOSTS_DEFAULT)
                hosts_eff <= pwdata[7:0];
        end
        else if (wr && hit(paddr, `SSLR_REG_BOOT))
        begin
            boot_sub  <= pwdata[15:0];
            boot_type <= pwdata[31:16];
        end
    end

    // fault code selection; a format check on each message
    always @*
    begin
        code_wr      = 1'b0;
        code_wr_data = sw_code;
        if (wr && hit(paddr, `SSLR_REG_CODE))
        begin
            code_wr = 1'b1;
            code_wr_data = pwdata[7:0];
        end
        else if (wr && hit(paddr, `SSLR_REG_CFG) &&
                 pwdata[31:8] != `SSLR_RSVD_REQ)
        begin
            code_wr = 1'b1;
            code_wr_data = `SSLR_CODE_BAD_FORMAT;
        end
        else if (wr && hit(paddr, `SSLR_REG_BOOT) &&
                 (pwdata[15:0] != `SSLR_BOOT_SUBTYPE ||
                  pwdata[31:16] != `SSLR_BOOT_FRAME_TYPE))
        begin
            code_wr = 1'b1;
            code_wr_data = `SSLR_CODE_BOOT_FAIL;
        end
    end

    // remember what software asked for, for readback
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sw_code <= 8'h00;
        else if (code_wr)
            sw_code <= code_wr_data;
    end

    sslr_code_store #(
        .WIDTH   (8)
    ) u_store (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (code_wr),
        .wr_data (code_wr_data),
        .rd_data (code)
    );

    // restart request is a one-cycle strobe from ctrl
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            restart <= 1'b0;
        else
            restart <= wr && hit(paddr, `SSLR_REG_CTRL) &&
                       pwdata[`SSLR_CTRL_RESTART];
    end

    // top-level state: test, ready, initialized, fault
    always @*
    begin
        next_state = state;
        case (state)
            ST_TEST:
                if (wr && hit(paddr, `SSLR_REG_CTRL))
                begin
                    if (pwdata[`SSLR_CTRL_TEST_FAIL])
                        next_state = pwdata[`SSLR_CTRL_STEADY] ?
                                     ST_HOLD : ST_CODE;
                    else if (pwdata[`SSLR_CTRL_TEST_DONE])
                        next_state = ST_READY;
                end
            ST_READY:
                if (wr && hit(paddr, `SSLR_REG_CTRL) &&
                    pwdata[`SSLR_CTRL_INIT_DONE])
                    next_state = ST_INIT;
            ST_INIT:
                next_state = ST_INIT;
            ST_HOLD:
                next_state = ST_HOLD;
            ST_CODE:
                next_state = ST_CODE;
            default:
                next_state = ST_TEST;
        endcase
        // software config failures report via code
        if ((state == ST_READY || state == ST_INIT) && code_wr)
            next_state = ST_CODE;
        if (wr && hit(paddr, `SSLR_REG_CTRL) &&
            pwdata[`SSLR_CTRL_CFG_FAIL])
            next_state = ST_CODE;
        if (restart)
            next_state = ST_TEST;
    end

    assign cur_bit   = code[3'd7 - bit_idx];
    assign pulse_len = cur_bit ? LONG_TICKS[15:0]
                               : SHORT_TICKS[15:0];

    // sequencer for blinking and pulse trains
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state   <= ST_TEST;
            phase   <= PH_PAUSE;
            bit_idx <= 3'd0;
            ticks   <= 16'h0000;
            blink   <= 1'b1;
        end
        else if (next_state != state)
        begin
            // every new mode starts from a clean pause
            state   <= next_state;
            phase   <= PH_PAUSE;
            bit_idx <= 3'd0;
            ticks   <= 16'h0000;
            blink   <= 1'b1;
        end
        else if (tick)
        begin
            ticks <= ticks + 16'h0001;
            if (state == ST_READY && ticks >= BLINK_TICKS - 1)
            begin
                ticks <= 16'h0000;
                blink <= ~blink;
            end
            else if (state == ST_CODE)
            begin
                case (phase)
                    PH_PAUSE:
                        if (ticks >= PAUSE_TICKS - 1)
                        begin
                            phase <= PH_PULSE;
                            ticks <= 16'h0000;
                        end
                    PH_PULSE:
                        if (ticks >= pulse_len - 16'h0001)
                        begin
                            ticks <= 16'h0000;
                            if (bit_idx == 3'd7)
                            begin
                                phase   <= PH_PAUSE;
                                bit_idx <= 3'd0;
                            end
                            else
                                phase <= PH_GAP;
                        end
                    PH_GAP:
                        if (ticks >= GAP_TICKS - 1)
                        begin
                            phase   <= PH_PULSE;
                            ticks   <= 16'h0000;
                            bit_idx <= bit_idx + 3'd1;
                        end
                    default:
                        phase <= PH_PAUSE;
                endcase
            end
        end
    end

    // indicator drive, registered
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_indicator <= 1'b1;
        else
            case (next_state)
                ST_TEST:  status_indicator <= 1'b1;
                ST_READY: status_indicator <= blink;
                ST_INIT:  status_indicator <= 1'b0;
                ST_HOLD:  status_indicator <= 1'b1;
                ST_CODE:  status_indicator <= (phase == PH_PULSE) &&
                                              (state == ST_CODE);
                default:  status_indicator <= 1'b1;
            endcase
    end

    // read mux, registered in the setup cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd && !penable)
        begin
            prdata <= 32'h0000_0000;
            if (hit(paddr, `SSLR_REG_CODE))
                prdata <= {24'h000000, sw_code};
            else if (hit(paddr, `SSLR_REG_STATUS))
                // exactly 32 bits: host count stays in [15:8]
                prdata <= {16'h0000, hosts_eff, bit_idx, phase, state};
            else if (hit(paddr, `SSLR_REG_CFG))
                prdata <= {rsvd_in, hosts_in};
            else if (hit(paddr, `SSLR_REG_BOOT))
                prdata <= {boot_type, boot_sub};
            else if (hit(paddr, `SSLR_REG_TIMING))
                prdata <= {24'h000000, 5'b00000, state};
        end
    end

endmodule

`default_nettype wire

// ---- dv/sslr_top_sva.sv ----
`default_nettype none
// ==========================================================
// port checker for the status reporter
module sslr_top_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        status_indicator
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic acc;
    wire logic bad;
    wire logic rd_setup;
    // decode once; anything past the last word is unmapped
    assign acc      = psel && penable;
    assign bad      = paddr[11:2] > 10'h005;
    assign rd_setup = psel && !penable && !pwrite;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready; psel |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready in transfer");
    property p_err; acc && bad |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
    property p_ok; acc && !bad |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped word refused");
    property p_err_acc; pslverr |-> acc; endproperty
    a_err_acc: assert property (p_err_acc) else $error("stray error flag");
    property p_rd_zero; acc && bad && !pwrite |-> prdata == 32'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("unmapped read data");
    property p_rd_hold; $changed(prdata) |-> $past(rd_setup); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_reset_on; $rose(presetn) |-> status_indicator [*4];
    endproperty
    a_reset_on: assert property (p_reset_on)
        else $error("led off at start");
    property p_init_off;
        acc && pwrite && paddr == 12'h000 && pwdata[5:0] == 6'h04
            |-> ##[1:4] !status_indicator [*8];
    endproperty
    a_init_off: assert property (p_init_off)
        else $error("led on after init");
endmodule

bind sslr_top sslr_top_sva u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .status_indicator(status_indicator));
`default_nettype wire

// ---- dv/sslr_led_watch.sv ----
`default_nettype none
// ==========================================================
// led watcher: turns pulse lengths back into code bytes
module sslr_led_watch #(
    parameter int LONG_MIN  = 8,
    parameter int PAUSE_MIN = 18
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       status_indicator,
    output logic [7:0]      code,
    output logic            done
);
    timeunit 1ns;
    timeprecision 1ns;
    int         run;
    int         n_bits;
    logic       last;
    logic [7:0] sh;

    // a high run past the pause limit is a steady level, not a bit
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run <= 0;
            n_bits <= 0;
            last <= 1'b1;
            sh <= 8'h00;
            code <= 8'h00;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            last <= status_indicator;
            run <= (status_indicator == last) ? run + 1 : 1;
            if (last && !status_indicator)
            begin
                sh <= {sh[6:0], run >= LONG_MIN};
                n_bits <= (run < PAUSE_MIN) ? n_bits + 1 : 0;
            end
            if (!last && status_indicator && run >= PAUSE_MIN)
            begin
                code <= sh;
                done <= n_bits == 8;
                n_bits <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/sslr_bench.sv ----
`include "sslr_defines.vh"
`default_nettype none
// ==========================================================
// self-checking bench: apb host, led decoder, queue model
module sslr_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 2;
    localparam int BL = 4;
    localparam int LG = 6;
    localparam int SH = 2;
    localparam int GP = 3;
    localparam int PS = 15;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        status_indicator;
    logic [7:0]  code;
    logic        done;
    logic [31:0] q;
    logic        err;
    int          n_errors = 0;
    int          compares = 0;
    int          cyc = 0;
    int          n;
    int          m;
    logic [7:0]  c;
    logic [7:0]  exp_q[$];
    // even slots self test codes, odd slots config codes
    logic [7:0]  tbl[8] = '{8'hB0, 8'hA0, 8'hB3, 8'hA4,
                            8'hB5, 8'hAC, 8'hBA, 8'hAF};

    always #20 pclk = ~pclk;

    sslr_top #(.TICK_CYCLES(TK), .LONG_TICKS(LG), .SHORT_TICKS(SH),
        .GAP_TICKS(GP), .PAUSE_TICKS(PS), .BLINK_TICKS(BL)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .status_indicator(status_indicator));
    // thresholds sit midway: short 4 / long 12, gap 6 / pause 30 clocks
    sslr_led_watch #(.LONG_MIN((LG + SH) * TK / 2),
        .PAUSE_MIN((GP + PS) * TK / 2)) u_watch (
        .pclk(pclk), .presetn(presetn), .status_indicator(status_indicator),
        .code(code), .done(done));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic ctrl(input logic [31:0] v);
        apb(1'b1, `SSLR_REG_CTRL, v);
    endtask

    task automatic hold(input logic v, input int len);
        m = 0;
        repeat (len)
        begin
            @(posedge pclk);
            m += (status_indicator === v);
        end
        check(m, len, "steady level");
    endtask

    task automatic run_len(input logic v);
        while (status_indicator !== v)
            @(posedge pclk);
        n = 0;
        while (status_indicator === v)
        begin
            n++;
            @(posedge pclk);
        end
    endtask

    task automatic show(input logic [7:0] v);
        exp_q.push_back(v);
        @(posedge pclk iff done === 1'b1);
        check(code, exp_q.pop_front(), "fault code");
    endtask

    task automatic test_done;
        if (n_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // cut a hang short; the whole run needs well under this
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            test_done();
        end
    end

    initial
    begin
        void'($urandom(32'h8970F3CC));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        hold(1'b1, 100);
        ctrl(32'h1);
        run_len(1'b0);
        run_len(1'b1);
        check(n, BL * TK, "blink on");
        run_len(1'b0);
        check(n, BL * TK, "blink off");
        // reserved field carries one in its low byte
        apb(1'b1, `SSLR_REG_CFG, 32'h0000_01FF);
        apb(1'b0, `SSLR_REG_STATUS, 32'h0);
        check(q[15:8], 8'h00, "first host count");
        apb(1'b1, `SSLR_REG_CFG, 32'h0000_0105);
        apb(1'b1, `SSLR_REG_CFG, 32'h0000_01FF);
        apb(1'b0, `SSLR_REG_STATUS, 32'h0);
        check(q[15:8], 8'h05, "later host count");
        apb(1'b1, `SSLR_REG_BOOT, 32'h1080_0000);
        ctrl(32'h4);
        hold(1'b0, 100);
        apb(1'b0, 12'h020, 32'h0);
        check(err, 1'b1, "unmapped error");
        check(q, 32'h0, "unmapped data");
        apb(1'b1, `SSLR_REG_CFG, 32'h0000_00FF);
        show(`SSLR_CODE_BAD_FORMAT);
        ctrl(32'h20);
        ctrl(32'h1);
        apb(1'b1, `SSLR_REG_BOOT, 32'h0001_1080);
        show(`SSLR_CODE_BOOT_FAIL);
        // odd passes use the config path, even the self test path
        for (int i = 0; i < 10; i++)
        begin
            c = (i < 8) ? tbl[i] : {i[0] ? 4'hA : 4'hB,
                4'($urandom_range(i[0] ? 15 : 10))};
            ctrl(32'h20);
            apb(1'b1, `SSLR_REG_CODE, {24'h0, c});
            ctrl(i[0] ? 32'h10 : 32'h2);
            show(c);
        end
        // steady fault from test; a later pass must not start blinking
        ctrl(32'h20);
        ctrl(32'hA);
        hold(1'b1, 100);
        ctrl(32'h1);
        hold(1'b1, 100);
        test_done();
    end
endmodule
`default_nettype wire
